/* File: ssd_defines.svh */
// Constants for the two-wire stretch, SMBus alert and DMA request block.
`ifndef SSD_DEFINES_SVH
`define SSD_DEFINES_SVH
`define SSD_CLK_PERIOD_PS     4000
`define SSD_TIMEOUT_US        35000
`define SSD_TIMEOUT_CYC       (`SSD_TIMEOUT_US * (1000000 / `SSD_CLK_PERIOD_PS))
`define SSD_SEXT_US           25000
`define SSD_SEXT_CYC          (`SSD_SEXT_US * (1000000 / `SSD_CLK_PERIOD_PS))
`define SSD_MEXT_US           10000
`define SSD_MEXT_CYC          (`SSD_MEXT_US * (1000000 / `SSD_CLK_PERIOD_PS))
`define SSD_ARA_ADDR          7'h0C
`define SSD_DEFAULT_ADDR      7'h61
`define SSD_HOST_ADDR         7'h08
`define SSD_CNT_W             24
`endif

/* File: ssd_pkg.sv */
// Types shared by the stretch, SMBus alert and DMA request block.
package ssd_pkg;
  typedef enum logic [1:0] {
    SSD_IDLE    = 2'b00,
    SSD_HOLD_TX = 2'b01,
    SSD_HOLD_RX = 2'b10
  } ssd_state_e;
endpackage

/* File: ssd_sync.sv */
// Two-flip-flop synchroniser for a bundle of pin levels.
`timescale 1ns/1ps
module ssd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // The first stage feeds only the second; reset starts at the pull-up level so no false low.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= '1;
      q_o  <= '1;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

/* File: ssd_top.sv */
// Clock stretching, overrun/underrun, SMBus alert, timeout and DMA request control.
//
// Functional notes
// (R01) Stretching on, transmitter: hold SCL low until status read then data write.
// (R02) Stretching on, receiver: hold SCL low until status read then data read.
// (R03) Slave, no stretch: unread byte at next arrival flags overrun, drops new byte.
// (R04) Slave, no stretch: empty buffer at next send flags underrun, resends byte.
// (R05) No write collision detection or flag when stretching is off.
// (R06) SMBus: SCL low over 35 ms is timeout; cumulative extensions are tracked.
// (R07) Timeout or extension violation reported by one status flag.
// (R08) Alert request bit pulls the wired-AND alert line low; here only in slave mode.
// (R09) Only a device pulling alert low acknowledges the alert response address.
// (R10) Alert response byte carries own 7-bit address in top seven bits.
// (R11) Several alerting devices: arbitration picks lowest address.
// (R12) After its address is acknowledged the device releases its alert pull-down.
// (R13) Host still seeing alert low reads the alert address again.
// (R14) Software sets SMBus mode first, then role and resolution enable.
// (R15) Default address acknowledged only with resolution on and device role.
// (R16) Host header acknowledged only with resolution on and host role.
// (R17) Alert response address acknowledged only while alert indication is set.
// (R18) DMA requests only for data bytes, never start, address or stop.
// (R19) DMA request when data register empties in send or fills in receive.
// (R20) Master transmitter software disables DMA and waits byte-finished before stop.
// (R21) Last bit set and penultimate signal seen: next received byte is NACKed.
// (R22) Master receiver software may request stop in DMA complete handler.
// (R23) Byte-finished set when transmit buffer empty at byte end; wait for clear.
// (R24) Byte-finished set when receive buffer full at next byte end; wait for read; not set here for a slave with stretching off.
// (R25) Stretched SCL released within a few cycles after required access.
`timescale 1ns/1ps
`include "ssd_defines.svh"
module ssd_top #(
  parameter int unsigned TIMEOUT_CYC = `SSD_TIMEOUT_CYC,
  parameter int unsigned SEXT_CYC    = `SSD_SEXT_CYC,
  parameter int unsigned MEXT_CYC    = `SSD_MEXT_CYC,
  parameter logic [6:0]  OWN_ADDR    = 7'h2A
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       scl_pin_i,
  input  wire logic       alert_pin_i,
  input  wire logic       stretch_disable_i,
  input  wire logic       slave_mode_i,
  input  wire logic       transmitter_i,
  input  wire logic       smbus_mode_i,
  input  wire logic       device_host_role_select_i,
  input  wire logic       address_resolution_enable_i,
  input  wire logic       alert_request_i,
  input  wire logic       dma_enable_i,
  input  wire logic       last_transfer_i,
  input  wire logic       data_phase_i,
  input  wire logic       byte_end_i,
  input  wire logic       tx_load_i,
  input  wire logic       rx_byte_i,
  input  wire logic       addr_valid_i,
  input  wire logic [6:0] addr_i,
  input  wire logic       alert_addr_acked_i,
  input  wire logic       status_read_i,
  input  wire logic       data_write_i,
  input  wire logic       data_read_i,
  input  wire logic       timeout_clear_i,
  input  wire logic       ovr_clear_i,
  input  wire logic       dma_penultimate_transfer_signal_i,
  output logic            scl_oe_o,
  output logic            alert_oe_o,
  output logic            tx_buffer_empty_flag_o,
  output logic            rx_buffer_full_flag_o,
  output logic            byte_finished_flag_o,
  output logic            overrun_flag_o,
  output logic            timeout_flag_o,
  output logic            alert_status_flag_o,
  output logic            addr_ack_o,
  output logic            resend_prev_o,
  output logic            drop_rx_o,
  output logic [7:0]      alert_reply_o,
  output logic            dma_req_o,
  output logic            auto_nack_o
);
  logic             scl_s;
  logic             alert_s;
  logic             status_seen;
  logic             pen_seen;
  logic             alert_served;
  logic             next_tx_empty;
  logic             next_rx_full;
  logic             next_byte_fin;
  ssd_pkg::ssd_state_e state;
  logic [`SSD_CNT_W-1:0] low_cnt;
  logic [`SSD_CNT_W-1:0] ext_cnt;
  logic             ack_match;

  // Pin levels cross into the clock domain before any logic looks at them.
  ssd_sync #(.W(2)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({scl_pin_i, alert_pin_i}),
    .q_o       ({scl_s, alert_s})
  );

  // Address compare used for every recognised SMBus address.
  function automatic logic addr_is(input logic [6:0] a, input logic [6:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // Buffer flags: a set from the core wins over a clear in the same cycle, but the matching data access blocks a byte-finished set.
  always_comb begin
    next_tx_empty = tx_buffer_empty_flag_o;
    next_rx_full  = rx_buffer_full_flag_o;
    next_byte_fin = byte_finished_flag_o;
    if (data_write_i) begin
      next_tx_empty = 1'b0;
      next_byte_fin = 1'b0;
    end
    if (data_read_i) begin
      next_rx_full  = 1'b0;
      next_byte_fin = 1'b0;
    end
    if (tx_load_i) begin
      next_tx_empty = 1'b1;
    end
    if (byte_end_i && data_phase_i && transmitter_i && tx_buffer_empty_flag_o
        && !data_write_i) begin
      next_byte_fin = 1'b1; // R23
    end
    if (rx_byte_i && data_phase_i && !transmitter_i) begin
      if (rx_buffer_full_flag_o && !data_read_i) begin
        next_byte_fin = next_byte_fin || !stretch_disable_i || !slave_mode_i; // R24
      end else begin
        next_rx_full = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_buffer_empty_flag_o <= 1'b1;
      rx_buffer_full_flag_o  <= 1'b0;
      byte_finished_flag_o   <= 1'b0;
    end else begin
      tx_buffer_empty_flag_o <= next_tx_empty;
      rx_buffer_full_flag_o  <= next_rx_full;
      byte_finished_flag_o   <= next_byte_fin;
    end
  end

  // Stretch state: hold SCL until the status read and then the data access.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state       <= ssd_pkg::SSD_IDLE;
      status_seen <= 1'b0;
    end else begin
      case (state)
        ssd_pkg::SSD_IDLE: begin
          status_seen <= 1'b0;
          if (!stretch_disable_i && next_byte_fin && !byte_finished_flag_o) begin
            state <= transmitter_i ? ssd_pkg::SSD_HOLD_TX : ssd_pkg::SSD_HOLD_RX;
          end
        end
        ssd_pkg::SSD_HOLD_TX: begin
          if (status_read_i) begin
            status_seen <= 1'b1;
          end
          if (status_seen && data_write_i) begin
            state <= ssd_pkg::SSD_IDLE; // R01
          end
        end
        ssd_pkg::SSD_HOLD_RX: begin
          if (status_read_i) begin
            status_seen <= 1'b1;
          end
          if (status_seen && data_read_i) begin
            state <= ssd_pkg::SSD_IDLE; // R02
          end
        end
        default: begin
          state <= ssd_pkg::SSD_IDLE;
        end
      endcase
    end
  end

  // SCL pull-down rises a cycle after the hold state and drops with the releasing access.
  // Only the access that the hold waits for releases it, so no one-cycle glitch appears.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_oe_o <= 1'b0;
    end else begin
      scl_oe_o <= (state != ssd_pkg::SSD_IDLE) && !(status_seen
                  && ((state == ssd_pkg::SSD_HOLD_TX) ? data_write_i : data_read_i)); // R25
    end
  end

  // Without stretching a slave cannot wait, so errors are flagged instead.
  // Write collisions are deliberately not detected here.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      overrun_flag_o <= 1'b0;
      drop_rx_o      <= 1'b0;
      resend_prev_o  <= 1'b0;
    end else begin
      drop_rx_o     <= 1'b0;
      resend_prev_o <= 1'b0;
      if (ovr_clear_i) begin
        overrun_flag_o <= 1'b0;
      end
      if (stretch_disable_i && slave_mode_i && data_phase_i) begin // R05
        if (rx_byte_i && !transmitter_i && rx_buffer_full_flag_o && !data_read_i) begin
          overrun_flag_o <= 1'b1; // R03
          drop_rx_o      <= 1'b1; // R03
        end
        if (byte_end_i && transmitter_i && tx_buffer_empty_flag_o && !data_write_i) begin
          overrun_flag_o <= 1'b1; // R04
          resend_prev_o  <= 1'b1; // R04
        end
      end
    end
  end

  // Clock-low timeout and cumulative extension counters; message bounds lie outside this
  // block, so the extension count only clears when SMBus mode is left.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_cnt        <= '0;
      ext_cnt        <= '0;
      timeout_flag_o <= 1'b0;
    end else begin
      if (!smbus_mode_i || scl_s) begin
        low_cnt <= '0;
      end else if (low_cnt != '1) begin
        low_cnt <= low_cnt + 1'b1;
      end
      if (!smbus_mode_i) begin
        ext_cnt <= '0;
      end else if (scl_oe_o && ext_cnt != '1) begin
        ext_cnt <= ext_cnt + 1'b1; // R06
      end
      if (timeout_clear_i) begin
        timeout_flag_o <= 1'b0;
      end
      if (smbus_mode_i && (low_cnt >= `SSD_CNT_W'(TIMEOUT_CYC)
          || (slave_mode_i && ext_cnt >= `SSD_CNT_W'(SEXT_CYC))
          || (!slave_mode_i && ext_cnt >= `SSD_CNT_W'(MEXT_CYC)))) begin
        timeout_flag_o <= 1'b1; // R07
      end
    end
  end

  // Address acknowledge for the SMBus special addresses and own address.
  always_comb begin
    ack_match = addr_is(addr_i, OWN_ADDR);
    if (smbus_mode_i && address_resolution_enable_i && !device_host_role_select_i
        && addr_is(addr_i, `SSD_DEFAULT_ADDR)) begin
      ack_match = 1'b1; // R15
    end
    if (smbus_mode_i && address_resolution_enable_i && device_host_role_select_i
        && addr_is(addr_i, `SSD_HOST_ADDR)) begin
      ack_match = 1'b1; // R16
    end
    if (smbus_mode_i && alert_oe_o && addr_is(addr_i, `SSD_ARA_ADDR)) begin
      ack_match = 1'b1; // R09 R17
    end
  end

  // Alert pull-down, reply byte and status; an answered request stays quiet until it drops.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alert_oe_o          <= 1'b0;
      alert_status_flag_o <= 1'b0;
      addr_ack_o          <= 1'b0;
      alert_reply_o       <= 8'h00;
      alert_served        <= 1'b0;
    end else begin
      addr_ack_o    <= addr_valid_i && ack_match;
      alert_reply_o <= {OWN_ADDR, 1'b0}; // R10
      alert_served  <= alert_request_i && (alert_served || alert_addr_acked_i); // R11
      if (alert_addr_acked_i || !alert_request_i || !smbus_mode_i) begin
        alert_oe_o <= 1'b0; // R12
      end else if (alert_request_i && !alert_oe_o && slave_mode_i && !alert_served) begin
        alert_oe_o <= 1'b1; // R08
      end
      alert_status_flag_o <= alert_status_flag_o;
      if (addr_valid_i && alert_oe_o && addr_is(addr_i, `SSD_ARA_ADDR)) begin
        alert_status_flag_o <= 1'b1; // R09
      end else if (!alert_s && !alert_oe_o) begin
        alert_status_flag_o <= 1'b0;
      end
    end
  end

  // DMA requests follow data-phase buffer events only.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dma_req_o   <= 1'b0;
      pen_seen    <= 1'b0;
      auto_nack_o <= 1'b0;
    end else begin
      dma_req_o <= dma_enable_i && data_phase_i
                   && ((transmitter_i && next_tx_empty && !tx_buffer_empty_flag_o)
                   || (!transmitter_i && next_rx_full && !rx_buffer_full_flag_o)); // R18 R19
      if (dma_penultimate_transfer_signal_i && last_transfer_i && !transmitter_i) begin
        pen_seen <= 1'b1;
      end else if (rx_byte_i && pen_seen) begin
        pen_seen <= 1'b0;
      end
      auto_nack_o <= pen_seen || (dma_penultimate_transfer_signal_i && last_transfer_i
                     && !transmitter_i); // R21
    end
  end

  stretch_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state == ssd_pkg::SSD_IDLE) |=> !scl_oe_o)
    else $error("SCL still held after stretch ended."); // R25
  hold_tx_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state == ssd_pkg::SSD_HOLD_TX && !status_seen) |=> state != ssd_pkg::SSD_IDLE)
    else $error("Transmit stretch ended without status read."); // R01
  hold_rx_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state == ssd_pkg::SSD_HOLD_RX && !(status_seen && data_read_i)) |=>
    state == ssd_pkg::SSD_HOLD_RX)
    else $error("Receive stretch ended early."); // R02
  overrun_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (stretch_disable_i && slave_mode_i && data_phase_i && rx_byte_i && !transmitter_i
     && rx_buffer_full_flag_o && !data_read_i) |=> overrun_flag_o && drop_rx_o)
    else $error("Overrun not flagged."); // R03
  underrun_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (stretch_disable_i && slave_mode_i && data_phase_i && byte_end_i && transmitter_i
     && tx_buffer_empty_flag_o && !data_write_i) |=> resend_prev_o)
    else $error("Underrun resend missing."); // R04
  alert_ack_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    addr_ack_o && $past(addr_i) == `SSD_ARA_ADDR && OWN_ADDR != `SSD_ARA_ADDR
    |-> $past(alert_oe_o))
    else $error("Alert address acked while not alerting."); // R17
  alert_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alert_addr_acked_i |=> !alert_oe_o)
    else $error("Alert pull-down not released."); // R12
  dma_data_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    dma_req_o |-> $past(data_phase_i) && $past(dma_enable_i))
    else $error("DMA request outside data phase."); // R18
  timeout_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (smbus_mode_i && low_cnt >= `SSD_CNT_W'(TIMEOUT_CYC)) |=> timeout_flag_o)
    else $error("Clock-low timeout not flagged."); // R06
endmodule

/* File: ssd_bus_model.sv */
// Far-side model: the remote clocking master and other alerting devices on the wires.
`timescale 1ns/1ps
module ssd_bus_model (
  input  wire logic frame_i,
  input  wire logic hold_low_i,
  input  wire logic other_alert_i,
  input  wire logic scl_oe_i,
  input  wire logic alert_oe_i,
  output logic      scl_pin_o,
  output logic      alert_pin_o
);
  logic sclk;
  // The remote master toggles the clock only inside frames, so idle time never looks like
  // clock-low; the odd start offset keeps every link edge clear of the block's own clock edges.
  initial begin
    sclk = 1'b1;
    #7;
    forever begin
      #24;
      sclk = frame_i ? ~sclk : 1'b1;
    end
  end
  // Wired-AND with pull-ups: any party pulling low wins, so the block sees its own stretch.
  assign scl_pin_o = sclk & ~hold_low_i & ~scl_oe_i;
  assign alert_pin_o = ~(alert_oe_i | other_alert_i);
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the stretch, SMBus alert and DMA request block.
`timescale 1ns/1ps
module tb_top;
  localparam int OSCL=0, OALR=1, OTXE=2, ORXF=3, OBTF=4, OOVR=5, OTMO=6, OACK=8, ORES=9,
    ODRP=10, ODMA=11, ONAK=12;
  localparam int PBE=0, PTL=1, PRX=2, PAV=3, PAA=4, PSR=5, PDW=6, PDR=7, PTC=8, POC=9, PPN=10;
  logic        clk, rst, sd, sm, tx, smb, role, are, areq, dmae, last, dph, frame, hold, oal;
  logic [10:0] pl;
  logic [6:0]  addr;
  logic [12:0] obs;
  logic [7:0]  reply;
  logic        scl, alrt, s;
  int          fails, n_checks;

  ssd_top #(.TIMEOUT_CYC(50), .SEXT_CYC(400), .MEXT_CYC(300)) u_dut (
    .clk_i(clk), .sys_rst_i(rst), .scl_pin_i(scl), .alert_pin_i(alrt),
    .stretch_disable_i(sd), .slave_mode_i(sm), .transmitter_i(tx), .smbus_mode_i(smb),
    .device_host_role_select_i(role), .address_resolution_enable_i(are),
    .alert_request_i(areq), .dma_enable_i(dmae), .last_transfer_i(last), .data_phase_i(dph),
    .byte_end_i(pl[PBE]), .tx_load_i(pl[PTL]), .rx_byte_i(pl[PRX]), .addr_valid_i(pl[PAV]),
    .addr_i(addr), .alert_addr_acked_i(pl[PAA]), .status_read_i(pl[PSR]),
    .data_write_i(pl[PDW]), .data_read_i(pl[PDR]), .timeout_clear_i(pl[PTC]),
    .ovr_clear_i(pl[POC]), .dma_penultimate_transfer_signal_i(pl[PPN]),
    .scl_oe_o(obs[0]), .alert_oe_o(obs[1]), .tx_buffer_empty_flag_o(obs[2]),
    .rx_buffer_full_flag_o(obs[3]), .byte_finished_flag_o(obs[4]), .overrun_flag_o(obs[5]),
    .timeout_flag_o(obs[6]), .alert_status_flag_o(obs[7]), .addr_ack_o(obs[8]),
    .resend_prev_o(obs[9]), .drop_rx_o(obs[10]), .alert_reply_o(reply), .dma_req_o(obs[11]),
    .auto_nack_o(obs[12]));

  ssd_bus_model u_bus (.frame_i(frame), .hold_low_i(hold), .other_alert_i(oal),
    .scl_oe_i(obs[0]), .alert_oe_i(obs[1]), .scl_pin_o(scl), .alert_pin_o(alrt));

  // Free-running system clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chb(input int k, input logic e);
    #1 chk({7'h00, obs[k]}, {7'h00, e});
  endtask

  task automatic pulse(input int k);
    @(posedge clk) pl <= 11'h001 << k;
    @(posedge clk) pl <= '0;
  endtask

  // Watching starts together with the pulse so a one-cycle answer is never missed.
  task automatic fire(input int k, input int o, input logic e);
    s = 1'b0;
    fork
      pulse(k);
      repeat (4) begin
        @(posedge clk);
        #1 s = s | obs[o];
      end
    join
    chk({7'h00, s}, {7'h00, e});
  endtask

  // Reset also restores a slave-transmitter, stretching, plain two-wire setup.
  task automatic do_reset(input int n);
    @(posedge clk);
    {rst, sd, smb, role, are, areq, dmae, last, frame, hold, oal} <= 11'h400;
    {sm, tx, dph, pl, addr} <= {3'h7, 11'h000, 7'h00};
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic s_reset();
    for (int k = 0; k < 13; k++) chb(k, k == OTXE);
    chk(reply, 8'h54);
  endtask

  task automatic s_tx_stretch();
    frame <= 1'b1;
    fire(PBE, OBTF, 1'b1);
    repeat (3) @(posedge clk);
    chb(OSCL, 1'b1);
    pulse(PSR);
    repeat (3) @(posedge clk);
    chb(OSCL, 1'b1);
    pulse(PDW);
    repeat (3) @(posedge clk);
    chb(OSCL, 1'b0);
    chb(OTXE, 1'b0);
    chb(OBTF, 1'b0);
    frame <= 1'b0;
  endtask

  task automatic s_rx_stretch();
    do_reset(3);
    {tx, dmae} <= 2'b01;
    fire(PRX, ODMA, 1'b1);
    chb(ORXF, 1'b1);
    fire(PRX, OBTF, 1'b1);
    repeat (3) @(posedge clk);
    chb(OSCL, 1'b1);
    pulse(PSR);
    pulse(PDR);
    repeat (3) @(posedge clk);
    chb(OSCL, 1'b0);
  endtask

  task automatic s_no_stretch();
    do_reset(3);
    {sd, tx} <= 2'b10;
    fire(PRX, ODRP, 1'b0);
    fire(PRX, ODRP, 1'b1);
    chb(OOVR, 1'b1);
    chb(OSCL, 1'b0);
    pulse(POC);
    repeat (2) @(posedge clk);
    chb(OOVR, 1'b0);
    do_reset(3);
    sd <= 1'b1;
    fire(PBE, ORES, 1'b1);
    chb(OOVR, 1'b1);
    chb(OSCL, 1'b0);
  endtask

  task automatic s_alert();
    do_reset(3);
    {smb, areq, addr} <= {2'b11, 7'h0C};
    repeat (3) @(posedge clk);
    chb(OALR, 1'b1);
    chk({7'h00, alrt}, 8'h00);
    fire(PAV, OACK, 1'b1);
    pulse(PAA);
    repeat (3) @(posedge clk);
    chb(OALR, 1'b0);
    {areq, oal} <= 2'b01;
    repeat (3) @(posedge clk);
    chk({7'h00, alrt}, 8'h00);
    fire(PAV, OACK, 1'b0);
  endtask

  // Every combination of resolution enable and role against both reserved addresses.
  task automatic s_arp();
    do_reset(3);
    smb <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {are, role, addr} <= {i[1:0], 7'h61};
      fire(PAV, OACK, i == 2);
      @(posedge clk) addr <= 7'h08;
      fire(PAV, OACK, i == 3);
    end
  endtask

  task automatic s_timeout();
    do_reset(3);
    {smb, hold} <= 2'b11;
    repeat (40) @(posedge clk);
    chb(OTMO, 1'b0);
    repeat (30) @(posedge clk);
    chb(OTMO, 1'b1);
    hold <= 1'b0;
    repeat (4) @(posedge clk);
    pulse(PTC);
    repeat (2) @(posedge clk);
    chb(OTMO, 1'b0);
  endtask

  task automatic s_dma();
    do_reset(3);
    {dmae, dph} <= 2'b10;
    pulse(PDW);
    fire(PTL, ODMA, 1'b0);
    dph <= 1'b1;
    pulse(PDW);
    fire(PTL, ODMA, 1'b1);
    dmae <= 1'b0;
    fire(PBE, OBTF, 1'b1);
    {tx, last} <= 2'b01;
    fire(PPN, ONAK, 1'b1);
    pulse(PRX);
    repeat (2) @(posedge clk);
    chb(ONAK, 1'b0);
  endtask

  task automatic complete_run();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence; every input has a value before the first edge.
  initial begin
    {rst, sd, smb, role, are, areq, dmae, last, frame, hold, oal} = 11'h400;
    {sm, tx, dph, pl, addr} = {3'h7, 11'h000, 7'h00};
    fails = 0;
    n_checks = 0;
    do_reset(16);
    s_reset();
    s_tx_stretch();
    s_rx_stretch();
    s_no_stretch();
    s_alert();
    s_arp();
    s_timeout();
    s_dma();
    complete_run();
  end

  // The whole sequence needs well under 2,000 cycles, so this only trips on a hang.
  initial begin
    #40000;
    fails++;
    complete_run();
  end
endmodule
